// ==== rtl/cidc_core.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cidc_defines.svh"

module cidc_core #(
	parameter int REG_COUNT = `CIDC_REG_COUNT
) (
	input wire logic i_clk, // 50 MHz system clock
	input wire logic i_resetn, // Async reset, active low
	input wire logic i_irq, // Interrupt request level
	output logic o_fetch_re, // Fetch read enable
	output logic [`CIDC_WADR_W-1:0] o_fetch_adr, // Fetch word index
	input wire logic [`CIDC_WORD_W-1:0] i_fetch_dat, // Fetched word
	input wire logic i_fetch_busy, // Fetch port stall
	output logic o_dbus_cyc, // Data cycle
	output logic o_dbus_stb, // Data strobe
	output logic o_dbus_we, // Data write enable
	output logic [`CIDC_LANES-1:0] o_dbus_sel, // Byte lanes
	output logic [`CIDC_WADR_W-1:0] o_dbus_adr, // Data word index
	output logic [`CIDC_WORD_W-1:0] o_dbus_dat, // Write data
	input wire logic i_dbus_ack, // Data acknowledge
	input wire logic [`CIDC_WORD_W-1:0] i_dbus_dat, // Read data
	output logic o_ready // Register clear done
);

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	// Decode fields are 8 bits wide, so the file must be exactly that deep
	generate
		if (REG_COUNT != `CIDC_REG_COUNT) begin : g_bad
			$error("cidc_core: REG_COUNT must equal the 8-bit field range");
		end
	endgenerate

	// ----------------------------------------
	// State
	// ----------------------------------------
	cidc_pkg::cidc_regs_t s_reg;
	cidc_pkg::cidc_regs_t s_next;
	logic ready_reg;

	// Register file as RAM; one read port, one write port
	logic [`CIDC_WORD_W-1:0] rf_mem [REG_COUNT]; // RQ10 RQ9
	logic [`CIDC_WORD_W-1:0] rf_q;
	logic [`CIDC_REG_W-1:0] rf_raddr;
	logic [`CIDC_REG_W-1:0] rf_waddr;
	logic [`CIDC_WORD_W-1:0] rf_wdata;
	logic rf_wen;

	// Fetched word seen through the field layout
	cidc_pkg::cidc_instr_t fetch_ir;
	assign fetch_ir = cidc_pkg::cidc_instr_t'(i_fetch_dat); // RQ8 RQ5

	// ----------------------------------------
	// Register file RAM
	// ----------------------------------------
	// No reset on the array so it maps to a RAM block; the clear sweep zeroes it
	always_ff @(posedge i_clk) begin
		if (rf_wen) begin
			rf_mem[rf_waddr] <= rf_wdata;
		end
		rf_q <= rf_mem[rf_raddr];
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		logic [`CIDC_WORD_W-1:0] tgt;
		logic [`CIDC_WORD_W-1:0] imm;
		logic [`CIDC_WORD_W-1:0] alu;
		logic [`CIDC_BYTE_W-1:0] lbyte;
		logic jump;
		tgt = rf_q;
		imm = '0;
		alu = '0;
		lbyte = '0;
		jump = 1'b0;
		s_next = s_reg;
		rf_raddr = '0;
		rf_waddr = '0;
		rf_wdata = '0;
		rf_wen = 1'b0;
		unique case (s_reg.st)
			// Sweep every register to zero after reset
			cidc_pkg::ST_CLEAR: begin
				rf_wen = 1'b1; // RQ11
				rf_waddr = s_reg.clr_idx;
				s_next.clr_idx = s_reg.clr_idx + 8'h01;
				if (&s_reg.clr_idx) begin
					s_next.st = cidc_pkg::ST_IDLE;
				end
			end
			// Take a pending interrupt, else start a fetch
			cidc_pkg::ST_IDLE: begin
				if (i_irq && !s_reg.in_irq) begin
					rf_raddr = `CIDC_REG_IV0;
					s_next.st = cidc_pkg::ST_IV;
				end else begin
					s_next.fre = 1'b1;
					s_next.st = cidc_pkg::ST_FWAIT;
				end
			end
			// Enter handler: return address with flag set goes to irp
			cidc_pkg::ST_IV: begin
				rf_wen = 1'b1;
				rf_waddr = `CIDC_REG_IRP;
				rf_wdata = {s_reg.pc, 2'h0};
				rf_wdata[`CIDC_IRF_BIT] = 1'b1; // RQ17
				s_next.pc = rf_q[`CIDC_WORD_W-1:2]; // RQ16
				s_next.in_irq = 1'b1;
				s_next.st = cidc_pkg::ST_IDLE;
			end
			// Wait until the fetch port accepts the word index
			cidc_pkg::ST_FWAIT: begin
				if (!i_fetch_busy) begin
					s_next.fre = 1'b0;
					s_next.st = cidc_pkg::ST_FCAP;
				end
			end
			// Word arrives one cycle after acceptance
			cidc_pkg::ST_FCAP: begin
				s_next.ir = fetch_ir; // RQ3
				s_next.pc = s_reg.pc + 30'h1; // RQ4
				rf_raddr = fetch_ir.src1; // RQ12
				s_next.st = cidc_pkg::ST_RD2;
			end
			// First operand: register or immediate byte
			cidc_pkg::ST_RD2: begin
				imm = {{(`CIDC_WORD_W-`CIDC_BYTE_W){s_reg.ir.src1[`CIDC_BYTE_W-1]}}, s_reg.ir.src1};
				s_next.a = s_reg.ir.t1 ? rf_q : imm; // RQ6 RQ2
				rf_raddr = s_reg.ir.src2;
				s_next.st = cidc_pkg::ST_RD3;
			end
			// Second operand, then the destination as a jump target
			cidc_pkg::ST_RD3: begin
				imm = {{(`CIDC_WORD_W-`CIDC_BYTE_W){s_reg.ir.src2[`CIDC_BYTE_W-1]}}, s_reg.ir.src2};
				s_next.b = s_reg.ir.t2 ? rf_q : imm; // RQ6 RQ2
				rf_raddr = s_reg.ir.dst;
				s_next.st = cidc_pkg::ST_EXEC;
			end
			// Execute; only the opcode chooses, unused fields are ignored
			cidc_pkg::ST_EXEC: begin
				s_next.st = cidc_pkg::ST_IDLE;
				unique case (s_reg.ir.opcode) // RQ5 RQ7
					`CIDC_OP_ADD: begin
						alu = s_reg.a + s_reg.b; // RQ8
						rf_wen = 1'b1;
					end
					`CIDC_OP_SUB: begin
						alu = s_reg.a - s_reg.b; // RQ2
						rf_wen = 1'b1;
					end
					`CIDC_OP_AND: begin
						alu = s_reg.a & s_reg.b;
						rf_wen = 1'b1;
					end
					`CIDC_OP_OR: begin
						alu = s_reg.a | s_reg.b;
						rf_wen = 1'b1;
					end
					`CIDC_OP_XOR: begin
						alu = s_reg.a ^ s_reg.b;
						rf_wen = 1'b1;
					end
					`CIDC_OP_LC: begin
						s_next.fre = 1'b1; // RQ3
						s_next.st = cidc_pkg::ST_KWAIT;
					end
					`CIDC_OP_JMP: begin
						tgt = s_reg.a; // RQ19
						jump = 1'b1;
					end
					`CIDC_OP_CALL: begin
						alu = {s_reg.pc, 2'h0}; // RQ18
						rf_wen = 1'b1;
						tgt = s_reg.a;
						jump = 1'b1;
					end
					`CIDC_OP_CJE: begin
						jump = (s_reg.a == s_reg.b); // RQ19
					end
					`CIDC_OP_CJSG: begin
						jump = ($signed(s_reg.a) > $signed(s_reg.b)); // RQ2 RQ19
					end
					`CIDC_OP_LW, `CIDC_OP_LUB, `CIDC_OP_LSB: begin
						s_next.cyc = 1'b1; // RQ13
						s_next.we = 1'b0;
						s_next.st = cidc_pkg::ST_MEM;
					end
					`CIDC_OP_SW, `CIDC_OP_SB: begin
						s_next.cyc = 1'b1; // RQ13
						s_next.we = 1'b1;
						s_next.st = cidc_pkg::ST_MEM;
					end
					default: begin
					end
				endcase
				// Pointer in the first operand; low two bits dropped for words
				s_next.dadr = s_reg.a[`CIDC_WORD_W-1:2]; // RQ15
				s_next.ddat = s_reg.b;
				s_next.sel = `CIDC_SEL_WORD;
				if (s_reg.ir.opcode == `CIDC_OP_SB) begin
					s_next.ddat = {`CIDC_LANES{s_reg.b[`CIDC_BYTE_W-1:0]}}; // RQ14
					s_next.sel = `CIDC_SEL_BYTE0 << s_reg.a[1:0]; // RQ14 RQ1
				end else if (s_reg.ir.opcode == `CIDC_OP_LUB || s_reg.ir.opcode == `CIDC_OP_LSB) begin
					s_next.sel = `CIDC_SEL_BYTE0 << s_reg.a[1:0];
				end
				// Call writes rp, the five ALU operations write dst
				rf_waddr = (s_reg.ir.opcode == `CIDC_OP_CALL) ? `CIDC_REG_RP : s_reg.ir.dst; // RQ18
				rf_wdata = alu;
				if (jump) begin
					s_next.pc = tgt[`CIDC_WORD_W-1:2]; // RQ16
					if (tgt[`CIDC_IRF_BIT]) begin
						s_next.in_irq = 1'b0; // RQ16
					end
				end
			end
			// Constant word fetch at the word after the opcode
			cidc_pkg::ST_KWAIT: begin
				if (!i_fetch_busy) begin
					s_next.fre = 1'b0;
					s_next.st = cidc_pkg::ST_KCAP;
				end
			end
			cidc_pkg::ST_KCAP: begin
				rf_wen = 1'b1; // RQ21
				rf_waddr = s_reg.ir.dst;
				rf_wdata = i_fetch_dat;
				s_next.pc = s_reg.pc + 30'h1; // RQ21
				s_next.st = cidc_pkg::ST_IDLE;
			end
			// Data bus cycle held until the slave acknowledges
			cidc_pkg::ST_MEM: begin
				lbyte = i_dbus_dat[{s_reg.a[1:0], 3'h0} +: `CIDC_BYTE_W]; // RQ1 RQ14
				if (i_dbus_ack) begin
					s_next.cyc = 1'b0;
					s_next.we = 1'b0;
					s_next.st = cidc_pkg::ST_IDLE;
					rf_wen = !s_reg.we;
					rf_waddr = s_reg.ir.dst;
					unique case (s_reg.ir.opcode)
						`CIDC_OP_LSB: begin
							rf_wdata = {{(`CIDC_WORD_W-`CIDC_BYTE_W){lbyte[`CIDC_BYTE_W-1]}}, lbyte};
						end
						`CIDC_OP_LUB: begin
							rf_wdata = {{(`CIDC_WORD_W-`CIDC_BYTE_W){1'b0}}, lbyte};
						end
						default: begin
							rf_wdata = i_dbus_dat; // RQ15
						end
					endcase
				end
			end
			default: begin
				s_next.st = cidc_pkg::ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Reset lands in the clear sweep with pc, flags and bus idle
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_reg <= '0; // RQ11
			ready_reg <= 1'b0;
		end else begin
			s_reg <= s_next;
			ready_reg <= (s_reg.st != cidc_pkg::ST_CLEAR);
		end
	end

	// ----------------------------------------
	// Outputs, all straight from flops
	// ----------------------------------------
	assign o_fetch_re = s_reg.fre; // RQ20
	assign o_fetch_adr = s_reg.pc; // RQ4
	assign o_dbus_cyc = s_reg.cyc;
	assign o_dbus_stb = s_reg.cyc;
	assign o_dbus_we = s_reg.we;
	assign o_dbus_sel = s_reg.sel;
	assign o_dbus_adr = s_reg.dadr;
	assign o_dbus_dat = s_reg.ddat;
	assign o_ready = ready_reg;

endmodule

`default_nettype wire

// ==== rtl/cidc_defines.svh ====
// What this block does
// (RQ1) Data words are 32 bits; byte lanes are little-endian.
// (RQ2) Signed values and immediates are two's complement in arithmetic and compares.
// (RQ3) Instructions are one word; load constant takes two fetched words.
// (RQ4) Fetch addresses are word indices only.
// (RQ5) Six-bit opcode in the top bits alone picks the operation.
// (RQ6) Type flag 1 means register number, else sign-extended immediate byte.
// (RQ7) Unused fields are zero and ignored.
// (RQ8) Layout: opcode 31:26, flags 25 and 24, dst, src1, src2; 010000 adds.
// (RQ9) 256 registers: 240 general, last 16 special.
// (RQ10) Register file lives in a RAM array, not flip-flops.
// (RQ11) Reset clears every register to zero.
// (RQ12) Stack pointer is ordinary; no implicit stack accesses.
// (RQ13) Memory addresses come from any register, indirectly.
// (RQ14) Byte loads and stores use the two low address bits to pick a lane.
// (RQ15) Word accesses ignore the two low address bits.
// (RQ16) Instruction pointer bit 0 is the interrupt return flag.
// (RQ17) Interrupt entry saves return address with bit 0 set.
// (RQ18) Call saves next address in return pointer, then jumps.
// (RQ19) Return is a jump through return pointer; compare-jumps may use it.
// (RQ20) Low-latency fetch variant; one instruction set for all variants.
// (RQ21) Load constant writes second word to dst, continues after it.
`ifndef CIDC_DEFINES_SVH
`define CIDC_DEFINES_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define CIDC_WORD_W 32
`define CIDC_BYTE_W 8
`define CIDC_OPC_W 6
`define CIDC_REG_W 8
`define CIDC_WADR_W 30
`define CIDC_LANES 4
`define CIDC_REG_COUNT 256
`define CIDC_GEN_COUNT 240
`define CIDC_IRF_BIT 0

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define CIDC_OP_NOP 6'h00
`define CIDC_OP_LC 6'h01
`define CIDC_OP_LW 6'h08
`define CIDC_OP_LUB 6'h0A
`define CIDC_OP_LSB 6'h0B
`define CIDC_OP_ADD 6'h10
`define CIDC_OP_SUB 6'h11
`define CIDC_OP_SW 6'h18
`define CIDC_OP_SB 6'h1A
`define CIDC_OP_AND 6'h20
`define CIDC_OP_OR 6'h21
`define CIDC_OP_XOR 6'h22
`define CIDC_OP_JMP 6'h30
`define CIDC_OP_CJE 6'h31
`define CIDC_OP_CJSG 6'h32
`define CIDC_OP_CALL 6'h3C

// ----------------------------------------
// Special registers and lanes
// ----------------------------------------
`define CIDC_REG_IV0 8'hF0
`define CIDC_REG_IRP 8'hFD
`define CIDC_REG_RP 8'hFE
`define CIDC_REG_SP 8'hFF
`define CIDC_SEL_WORD 4'hF
`define CIDC_SEL_BYTE0 4'h1

`endif

// ==== rtl/cidc_pkg.sv ====
`include "cidc_defines.svh"

package cidc_pkg;

	// Instruction word split, msb first
	typedef struct packed {
		logic [`CIDC_OPC_W-1:0] opcode;
		logic t1;
		logic t2;
		logic [`CIDC_REG_W-1:0] dst;
		logic [`CIDC_REG_W-1:0] src1;
		logic [`CIDC_REG_W-1:0] src2;
	} cidc_instr_t;

	typedef enum logic [3:0] {
		ST_CLEAR, ST_IDLE, ST_IV, ST_FWAIT, ST_FCAP, ST_RD2,
		ST_RD3, ST_EXEC, ST_KWAIT, ST_KCAP, ST_MEM
	} cidc_state_t;

	typedef struct packed {
		cidc_state_t st;
		logic [`CIDC_REG_W-1:0] clr_idx;
		logic [`CIDC_WADR_W-1:0] pc;
		cidc_instr_t ir;
		logic [`CIDC_WORD_W-1:0] a;
		logic [`CIDC_WORD_W-1:0] b;
		logic in_irq;
		logic fre;
		logic cyc;
		logic we;
		logic [`CIDC_LANES-1:0] sel;
		logic [`CIDC_WADR_W-1:0] dadr;
		logic [`CIDC_WORD_W-1:0] ddat;
	} cidc_regs_t;

endpackage

// ==== verification/cidc_core_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Port protocol checker
// ----------------------------------------
module cidc_core_sva #(
	parameter int REG_COUNT = 256
) (
	input wire logic i_clk, // Clock
	input wire logic i_resetn, // Reset, active low
	input wire logic o_fetch_re, // Fetch enable
	input wire logic [29:0] o_fetch_adr, // Fetch index
	input wire logic i_fetch_busy, // Fetch stall
	input wire logic o_dbus_cyc, // Data cycle
	input wire logic o_dbus_stb, // Data strobe
	input wire logic o_dbus_we, // Write enable
	input wire logic [3:0] o_dbus_sel, // Lanes
	input wire logic [29:0] o_dbus_adr, // Data index
	input wire logic [31:0] o_dbus_dat, // Write data
	input wire logic i_dbus_ack, // Acknowledge
	input wire logic o_ready // Clear done
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	// Nothing leaves the core until the register sweep is over
	property p_ready_holds; o_ready |=> o_ready; endproperty
	a_ready_holds: assert property (p_ready_holds) else $error("ready dropped");
	property p_no_early_bus; !o_ready |-> !o_fetch_re && !o_dbus_cyc; endproperty
	a_no_early_bus: assert property (p_no_early_bus) else $error("bus used before clear");
	property p_fetch_hold; o_fetch_re && i_fetch_busy |=> o_fetch_re && $stable(o_fetch_adr); endproperty
	a_fetch_hold: assert property (p_fetch_hold) else $error("fetch not held");
	property p_fetch_once; o_fetch_re && !i_fetch_busy |=> !o_fetch_re; endproperty
	a_fetch_once: assert property (p_fetch_once) else $error("fetch repeated");
	property p_cyc_stb; o_dbus_cyc == o_dbus_stb; endproperty
	a_cyc_stb: assert property (p_cyc_stb) else $error("cyc and stb differ");
	// A slave may stall forever, so the request must not drift meanwhile
	property p_dbus_hold;
		o_dbus_cyc && !i_dbus_ack |=> o_dbus_cyc && $stable({o_dbus_we, o_dbus_sel, o_dbus_adr, o_dbus_dat});
	endproperty
	a_dbus_hold: assert property (p_dbus_hold) else $error("data request changed");
	property p_dbus_end; o_dbus_cyc && i_dbus_ack |=> !o_dbus_cyc; endproperty
	a_dbus_end: assert property (p_dbus_end) else $error("cycle outlived ack");
	property p_byte_lane; o_dbus_cyc && o_dbus_sel != 4'hF |-> $onehot(o_dbus_sel); endproperty
	a_byte_lane: assert property (p_byte_lane) else $error("bad lane select");
	property p_byte_copy; o_dbus_cyc && o_dbus_we && o_dbus_sel != 4'hF |-> o_dbus_dat == {4{o_dbus_dat[7:0]}}; endproperty
	a_byte_copy: assert property (p_byte_copy) else $error("byte not copied to lanes");

	c_ready: cover property ($rose(o_ready));
	c_stall: cover property (o_fetch_re && i_fetch_busy);
	c_byte_wr: cover property (o_dbus_cyc && o_dbus_we && o_dbus_sel != 4'hF);
endmodule

bind cidc_core cidc_core_sva #(.REG_COUNT(REG_COUNT)) chk_u (.i_clk(i_clk), .i_resetn(i_resetn),
	.o_fetch_re(o_fetch_re), .o_fetch_adr(o_fetch_adr), .i_fetch_busy(i_fetch_busy), .o_dbus_cyc(o_dbus_cyc),
	.o_dbus_stb(o_dbus_stb), .o_dbus_we(o_dbus_we), .o_dbus_sel(o_dbus_sel), .o_dbus_adr(o_dbus_adr),
	.o_dbus_dat(o_dbus_dat), .i_dbus_ack(i_dbus_ack), .o_ready(o_ready));
`default_nettype wire

// ==== verification/cidc_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Instruction memory and data slave
// ----------------------------------------
module cidc_mem_model (
	input wire logic i_clk, // Clock
	input wire logic i_slow, // Stall mode
	input wire logic i_re, // Fetch request
	input wire logic [29:0] i_fadr, // Fetch index
	output logic o_busy, // Fetch stall
	output logic [31:0] o_fdat, // Fetched word
	input wire logic i_cyc, // Data cycle
	input wire logic i_we, // Write enable
	input wire logic [3:0] i_sel, // Lanes
	input wire logic [29:0] i_adr, // Data index
	input wire logic [31:0] i_dat, // Write data
	output logic o_ack, // Acknowledge
	output logic [31:0] o_rdat // Read data
);
	logic [31:0] imem [0:63];
	logic [31:0] dmem [0:255];
	logic [1:0] wcnt;

	initial begin
		o_busy = 1'b0;
		o_fdat = 32'h0;
		o_ack = 1'b0;
		wcnt = 2'h0;
	end
	// Fetch answers a cycle after acceptance; stale data is inverted, never held
	always @(posedge i_clk) begin
		o_busy <= i_slow & ~o_busy;
		o_fdat <= (i_re && !o_busy) ? imem[i_fadr[5:0]] : ~o_fdat;
	end
	// Slow mode adds wait states before each acknowledge
	always @(posedge i_clk) begin
		wcnt <= (i_cyc && !o_ack) ? wcnt + 2'h1 : 2'h0;
		o_ack <= i_cyc && !o_ack && (wcnt >= (i_slow ? 2'h2 : 2'h0));
		if (i_cyc && o_ack && i_we)
			for (int k = 0; k < 4; k++)
				if (i_sel[k]) dmem[i_adr[7:0]][8*k +: 8] <= i_dat[8*k +: 8];
	end
	assign o_rdat = o_ack ? dmem[i_adr[7:0]] : ~dmem[i_adr[7:0]];
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cidc_defines.svh"
module tb;
	logic clk = 1'b0, resetn = 1'b0, irq = 1'b0, slow = 1'b0;
	logic fre, fbusy, cyc, stb, we, ack, rdy;
	logic [29:0] fadr, dadr;
	logic [31:0] fdat, wdat, rdat;
	logic [3:0] sel;
	int error_cnt = 0, num_checks = 0, tick_cnt = 0, pi;
	logic [65:0] wq [$];

	always #10 clk = ~clk;

	cidc_core #(.REG_COUNT(256)) dut_u (.i_clk(clk), .i_resetn(resetn), .i_irq(irq), .o_fetch_re(fre),
		.o_fetch_adr(fadr), .i_fetch_dat(fdat), .i_fetch_busy(fbusy), .o_dbus_cyc(cyc), .o_dbus_stb(stb),
		.o_dbus_we(we), .o_dbus_sel(sel), .o_dbus_adr(dadr), .o_dbus_dat(wdat), .i_dbus_ack(ack),
		.i_dbus_dat(rdat), .o_ready(rdy));
	cidc_mem_model mem_u (.i_clk(clk), .i_slow(slow), .i_re(fre), .i_fadr(fadr), .o_busy(fbusy), .o_fdat(fdat),
		.i_cyc(cyc), .i_we(we), .i_sel(sel), .i_adr(dadr), .i_dat(wdat), .o_ack(ack), .o_rdat(rdat));

	// ----------------------------------------
	// Write monitor and hang guard
	// ----------------------------------------
	always @(posedge clk) begin
		if (cyc && ack && we) wq.push_back({dadr, sel, wdat});
		tick_cnt++;
		if (tick_cnt == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	task tally_and_finish;
		if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk_word(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t word %h expected %h", $time, g, e);
		end
	endtask
	task chk_xfer(input logic [65:0] g, input logic [65:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t transfer %h expected %h", $time, g, e);
		end
	endtask

	// ----------------------------------------
	// Program image
	// ----------------------------------------
	function automatic logic [31:0] e(input logic [5:0] o, input logic [1:0] t, input logic [7:0] d, a, b);
		return {o, t, d, a, b};
	endfunction
	task put(input logic [31:0] w);
		mem_u.imem[pi] = w;
		pi++;
	endtask
	task lc(input logic [7:0] d, input logic [31:0] k);
		put(e(`CIDC_OP_LC, 2'h0, d, 8'h00, 8'h00));
		put(k);
	endtask
	// Byte ops on lane 2, sign work, call and return, then an interrupt handler
	task load_prog;
		for (int i = 0; i < 256; i++) mem_u.dmem[i] = 32'hA5A5A5A5;
		for (int i = 0; i < 64; i++) mem_u.imem[i] = 32'h0;
		pi = 0;
		lc(8'h01, 32'h00000102);
		lc(8'h02, 32'h8899AABB);
		put(e(`CIDC_OP_SW, 2'h3, 8'h00, 8'h01, 8'h02));
		put(e(`CIDC_OP_SB, 2'h2, 8'h00, 8'h01, 8'hFD));
		put(e(`CIDC_OP_LSB, 2'h2, 8'h03, 8'h01, 8'h00));
		put(e(`CIDC_OP_LUB, 2'h2, 8'h04, 8'h01, 8'h00));
		put(e(`CIDC_OP_ADD, 2'h2, 8'h05, 8'h03, 8'h0A));
		lc(8'h06, 32'h00000050);
		put(e(`CIDC_OP_CALL, 2'h2, 8'h00, 8'h06, 8'h00));
		put(e(`CIDC_OP_SW, 2'h3, 8'h00, 8'h08, 8'h03));
		put(e(`CIDC_OP_SW, 2'h3, 8'h00, 8'h09, 8'h04));
		put(e(`CIDC_OP_SW, 2'h3, 8'h00, 8'h0A, 8'h05));
		put(e(`CIDC_OP_SW, 2'h3, 8'h00, 8'h0B, 8'h0C));
		put(e(`CIDC_OP_ADD, 2'h2, 8'h0B, 8'h0B, 8'h04));
		put(e(`CIDC_OP_SW, 2'h3, 8'h00, 8'h0B, 8'h64));
		put(e(`CIDC_OP_JMP, 2'h2, 8'h00, 8'h0D, 8'h00));
		pi = 20;
		lc(8'h08, 32'h00000203);
		put(e(`CIDC_OP_ADD, 2'h2, 8'h09, 8'h08, 8'h04));
		put(e(`CIDC_OP_ADD, 2'h2, 8'h0A, 8'h09, 8'h04));
		put(e(`CIDC_OP_ADD, 2'h2, 8'h0B, 8'h0A, 8'h04));
		put(e(`CIDC_OP_ADD, 2'h2, 8'h0C, `CIDC_REG_RP, 8'h00));
		lc(8'h0D, 32'h00000048);
		lc(`CIDC_REG_IV0, 32'h000000E0);
		put(e(`CIDC_OP_SUB, 2'h2, 8'h0E, 8'h05, 8'h0A));
		put(e(`CIDC_OP_XOR, 2'h3, 8'h0F, 8'h02, 8'h0E));
		put(e(`CIDC_OP_AND, 2'h2, 8'h10, 8'h02, 8'h0F));
		put(e(`CIDC_OP_OR, 2'h2, 8'h10, 8'h10, 8'hF0));
		lc(8'h14, 32'h00000218);
		put(e(`CIDC_OP_SW, 2'h3, 8'h00, 8'h14, 8'h0E));
		put(e(`CIDC_OP_ADD, 2'h2, 8'h14, 8'h14, 8'h04));
		put(e(`CIDC_OP_SW, 2'h3, 8'h00, 8'h14, 8'h0F));
		put(e(`CIDC_OP_ADD, 2'h2, 8'h14, 8'h14, 8'h04));
		put(e(`CIDC_OP_SW, 2'h3, 8'h00, 8'h14, 8'h10));
		put(e(`CIDC_OP_LW, 2'h2, 8'h11, 8'h01, 8'h00));
		put(e(`CIDC_OP_ADD, 2'h2, 8'h14, 8'h14, 8'h04));
		put(e(`CIDC_OP_SW, 2'h3, 8'h00, 8'h14, 8'h11));
		// Signed compare must not jump; equal compare skips one increment
		lc(8'h15, 32'h000000C8);
		put(e(`CIDC_OP_CJSG, 2'h3, 8'h15, 8'h0E, 8'h05));
		put(e(`CIDC_OP_ADD, 2'h2, 8'h14, 8'h14, 8'h04));
		put(e(`CIDC_OP_CJE, 2'h3, 8'h15, 8'h11, 8'h11));
		put(e(`CIDC_OP_ADD, 2'h2, 8'h14, 8'h14, 8'h04));
		put(e(`CIDC_OP_SW, 2'h3, 8'h00, 8'h14, 8'h0E));
		put(e(`CIDC_OP_JMP, 2'h2, 8'h00, `CIDC_REG_RP, 8'h00));
		pi = 56;
		put(e(`CIDC_OP_ADD, 2'h2, 8'h0B, 8'h0B, 8'h04));
		put(e(`CIDC_OP_SW, 2'h3, 8'h00, 8'h0B, `CIDC_REG_IRP));
		put(e(`CIDC_OP_JMP, 2'h2, 8'h00, 8'h0D, 8'h00));
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task do_reset;
		@(negedge clk) resetn = 1'b0;
		load_prog;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
	endtask
	task wait_mem(input logic [7:0] a);
		for (int i = 0; i < 4000 && mem_u.dmem[a] === 32'hA5A5A5A5; i++) @(negedge clk);
	endtask
	task scen_reset_sweep;
		int n;
		do_reset;
		n = 0;
		while (rdy !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk_word({31'h0, n >= 256 && n <= 259}, 32'h1);
	endtask
	task run_prog(input logic s);
		slow = s;
		do_reset;
		wq.delete();
		wait_mem(8'h84);
		irq = 1'b1;
		wait_mem(8'h85);
		irq = 1'b0;
		chk_xfer(wq[0], {30'h40, 4'hF, 32'h8899AABB});
		chk_xfer(wq[1], {30'h40, 4'h4, 32'hFDFDFDFD});
		chk_word(mem_u.dmem[8'h40], 32'h88FDAABB);
		chk_word(mem_u.dmem[8'h80], 32'hFFFFFFFD);
		chk_word(mem_u.dmem[8'h81], 32'h000000FD);
		chk_word(mem_u.dmem[8'h82], 32'h00000007);
		chk_word(mem_u.dmem[8'h83], 32'h00000030);
		chk_word(mem_u.dmem[8'h84], 32'h00000000);
		chk_word(mem_u.dmem[8'h85], 32'h00000049);
		chk_word(mem_u.dmem[8'h86], 32'hFFFFFFFD);
		chk_word(mem_u.dmem[8'h87], 32'h77665546);
		chk_word(mem_u.dmem[8'h88], 32'hFFFFFFFB);
		chk_word(mem_u.dmem[8'h89], 32'h88FDAABB);
		chk_word(mem_u.dmem[8'h8A], 32'hFFFFFFFD);
	endtask

	initial begin
		scen_reset_sweep;
		run_prog(1'b0);
		run_prog(1'b1);
		tally_and_finish;
	end
endmodule
`default_nettype wire
